// ==== include/pt8_map.svh ====
// register offsets, field positions, reset values and counter widths of the period timer
`ifndef PT8_MAP_SVH
`define PT8_MAP_SVH
`define PT8_ADDR_W          3
`define PT8_OFF_COUNT       3'h0
`define PT8_OFF_LIMIT       3'h1
`define PT8_OFF_CONTROL     3'h2
`define PT8_OFF_HLT         3'h3
`define PT8_OFF_STATUS      3'h4
`define PT8_OFF_PRESCALE    3'h5
`define PT8_COUNT_RST       8'h00
`define PT8_LIMIT_RST       8'hFF
`define PT8_CTRL_ON_BIT     7
`define PT8_CTRL_POSTSCALE_SELECT_LSB  0
`define PT8_CTRL_POSTSCALE_SELECT_MSB  3
`define PT8_CTRL_CKPS_LSB   4
`define PT8_CTRL_CKPS_MSB   6
`define PT8_HLT_MODE_LSB    0
`define PT8_HLT_MODE_MSB    4
`define PT8_STAT_EVENT_BIT  0
`define PT8_STAT_RUN_BIT    1
`define PT8_STAT_ERS_BIT    2
`define PT8_PRE_W           7
`define PT8_POST_W          4
`endif

// ==== include/pt8_pkg.sv ====
// types of the period timer
package pt8_pkg;
   typedef enum logic [1:0]
   {
      PT8_FREE,
      PT8_ONESHOT,
      PT8_MONO,
      PT8_RSVD
   } pt8_major_t;
   typedef enum logic [2:0]
   {
      PT8_SUB0,
      PT8_SUB1,
      PT8_SUB2,
      PT8_SUB3,
      PT8_SUB4,
      PT8_SUB5,
      PT8_SUB6,
      PT8_SUB7
   } pt8_sub_t;
endpackage : pt8_pkg

// ==== verilog/pt8_prescaler.sv ====
// prescaler divider giving one tick every 2^select input cycles
`timescale 1ns/100ps
`include "pt8_map.svh"
module pt8_prescaler
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        clear_i,
   input  wire logic        run_i,
   input  wire logic [2:0]  select_i,
   output logic             tick_o
);
   logic [`PT8_PRE_W-1:0] pre_count;
   logic [`PT8_PRE_W-1:0] pre_mask;

   assign pre_mask = 7'(({`PT8_PRE_W{1'b1}} << select_i) ^ {`PT8_PRE_W{1'b1}});
   assign tick_o   = run_i && ((pre_count & pre_mask) == pre_mask);

   // count cleared on device reset or clear request
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i || clear_i)
         pre_count <= '0;
      else if (run_i)
         pre_count <= pre_count + 7'h01;
   end
endmodule : pt8_prescaler

// ==== verilog/pt8_period_timer.sv ====
// 8-bit period timer with prescaler, postscaler and hardware limit modes
//
// Behaviour
// - 8-bit count and limit; free-running, one-shot and monostable modes.
// - prescaler divides input clock from 1:1 up to 1:128.
// - period matches feed postscaler selectable 1:1 to 1:16.
// - count increments on each prescaler tick in every mode.
// - on match count returns to 00h next tick; postscaler advances.
// - postscaler match gives a one-clock output pulse, then clears.
// - gate modes hold count while gate inactive, resume when active.
// - reset modes clear count on level or edge of external signal; the code clears the count only while the run bit is set.
// - software reads and writes count and limit at any time.
// - device reset clears count and sets limit to FFh.
// - prescaler and postscaler clear on count write, control write, resets.
// - control write leaves the count unchanged.
// - one-shot match clears run bit; restart needs software set again.
// - one-shot restart resets the postscaler.
// - monostable stops at match keeping run bit; external event restarts; in sub-mode 0 the code keeps counting through match.
// - debug freeze makes the timer ignore external trigger activity.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "pt8_map.svh"
module pt8_period_timer
   import pt8_pkg::*;
(
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic [`PT8_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]             wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   input  wire logic                   external_reset_signal_i,
   input  wire logic                   debug_freeze_i,
   output logic      [7:0]             rdata_o,
   output logic                        postscaled_period_pulse_o,
   output logic                        period_event_o
);
   logic [7:0]             period_count;
   logic [7:0]             period_limit;
   logic                   timer_run_bit;
   logic [3:0]             postscale_select;
   logic [2:0]             prescale_select;
   logic [4:0]             hw_mode;
   logic [`PT8_POST_W-1:0] post_count;
   logic                   ers_prev;
   logic                   armed;
   logic                   event_flag;
   logic                   run_prev;
   logic                   tick;
   logic                   wr_count;
   logic                   wr_limit;
   logic                   wr_ctrl;
   logic                   wr_hlt;
   logic                   wr_stat;
   logic                   ers;
   logic                   rise;
   logic                   fall;
   logic                   any_edge;
   logic                   match;
   logic                   post_hit;
   logic                   gate_ok;
   logic                   hw_reset;
   logic                   start_evt;
   logic                   counting;
   logic                   restart;
   pt8_major_t             major;
   pt8_sub_t               sub;

   assign major    = pt8_major_t'(hw_mode[4:3]);
   assign sub      = pt8_sub_t'(hw_mode[2:0]);
   assign wr_count = wr_i && (addr_i == `PT8_OFF_COUNT);
   assign wr_limit = wr_i && (addr_i == `PT8_OFF_LIMIT);
   assign wr_ctrl  = wr_i && (addr_i == `PT8_OFF_CONTROL);
   assign wr_hlt   = wr_i && (addr_i == `PT8_OFF_HLT);
   assign wr_stat  = wr_i && (addr_i == `PT8_OFF_STATUS);

   // external signal seen as constant while frozen
   assign ers      = debug_freeze_i ? ers_prev : external_reset_signal_i;
   assign rise     = ers && !ers_prev;
   assign fall     = !ers && ers_prev;
   assign any_edge = rise || fall;
   assign match    = (period_count == period_limit);
   assign post_hit = (post_count == postscale_select);

   // gate, reset and start decode per mode
   always_comb
   begin
      gate_ok   = 1'b1;
      hw_reset  = 1'b0;
      start_evt = 1'b0;
      unique case (major)
         PT8_FREE:
         begin
            unique case (sub)
               PT8_SUB0: gate_ok  = 1'b1;
               PT8_SUB1: gate_ok  = ers;
               PT8_SUB2: gate_ok  = !ers;
               PT8_SUB3: hw_reset = any_edge;
               PT8_SUB4: hw_reset = rise;
               PT8_SUB5: hw_reset = fall;
               PT8_SUB6: hw_reset = !ers;
               PT8_SUB7: hw_reset = ers;
            endcase
         end
         PT8_ONESHOT, PT8_MONO:
         begin
            unique case (sub)
               PT8_SUB0: start_evt = 1'b1;
               PT8_SUB1: start_evt = rise;
               PT8_SUB2: start_evt = fall;
               PT8_SUB3: start_evt = any_edge;
               PT8_SUB4:
               begin
                  start_evt = rise;
                  hw_reset  = (major == PT8_ONESHOT) && rise;
               end
               PT8_SUB5:
               begin
                  start_evt = fall;
                  hw_reset  = (major == PT8_ONESHOT) && fall;
               end
               PT8_SUB6:
               begin
                  start_evt = rise;
                  hw_reset  = (major == PT8_ONESHOT) && !ers;
               end
               PT8_SUB7:
               begin
                  start_evt = fall;
                  hw_reset  = (major == PT8_ONESHOT) && ers;
               end
            endcase
         end
         default:
            gate_ok = 1'b0;
      endcase
   end

   // advance only with run bit, gate and arming
   assign counting = timer_run_bit && gate_ok && (armed || start_evt) && !hw_reset;
   assign restart  = timer_run_bit && !run_prev;

   pt8_prescaler pt8_prescaler_inst
   (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .clear_i    (wr_count || wr_ctrl || hw_reset || restart),
      .run_i      (counting),
      .select_i   (prescale_select),
      .tick_o     (tick)
   );

   // count register
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         period_count <= `PT8_COUNT_RST;
      else if (wr_count)
         period_count <= wdata_i;
      else if (timer_run_bit && hw_reset)
         period_count <= 8'h00;
      else if (tick)
      begin
         if (match)
            period_count <= 8'h00;
         else
            period_count <= period_count + 8'h01;
      end
   end

   // limit register
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         period_limit <= `PT8_LIMIT_RST;
      else if (wr_limit)
         period_limit <= wdata_i;
   end

   // control register; count untouched on write
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         timer_run_bit    <= 1'b0;
         postscale_select <= 4'h0;
         prescale_select  <= 3'h0;
      end
      else if (wr_ctrl)
      begin
         timer_run_bit    <= wdata_i[`PT8_CTRL_ON_BIT];
         postscale_select <= wdata_i[`PT8_CTRL_POSTSCALE_SELECT_MSB:`PT8_CTRL_POSTSCALE_SELECT_LSB];
         prescale_select  <= wdata_i[`PT8_CTRL_CKPS_MSB:`PT8_CTRL_CKPS_LSB];
      end
      else if (tick && match && (major == PT8_ONESHOT))
         timer_run_bit <= 1'b0;
   end

   // mode register
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         hw_mode <= 5'h00;
      else if (wr_hlt)
         hw_mode <= wdata_i[`PT8_HLT_MODE_MSB:`PT8_HLT_MODE_LSB];
   end

   // arming: set by start, dropped at match in one-shot and monostable
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         armed <= 1'b0;
      else if (!timer_run_bit)
         armed <= 1'b0;
      else if (major == PT8_FREE)
         armed <= 1'b1;
      else if (tick && match)
         armed <= 1'b0;
      else if (start_evt)
         armed <= 1'b1;
   end

   // postscaler counter and output pulse
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i || wr_count || wr_ctrl || hw_reset || restart)
      begin
         post_count                <= '0;
         postscaled_period_pulse_o <= 1'b0;
      end
      else
      begin
         postscaled_period_pulse_o <= tick && match && post_hit;
         if (tick && match)
            post_count <= post_hit ? 4'h0 : post_count + 4'h1;
      end
   end

   // sticky event flag, write one to clear, set wins
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         event_flag <= 1'b0;
      else if (postscaled_period_pulse_o)
         event_flag <= 1'b1;
      else if (wr_stat && wdata_i[`PT8_STAT_EVENT_BIT])
         event_flag <= 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         ers_prev       <= 1'b0;
         run_prev       <= 1'b0;
         period_event_o <= 1'b0;
      end
      else
      begin
         ers_prev       <= ers;
         run_prev       <= timer_run_bit;
         period_event_o <= event_flag || postscaled_period_pulse_o;
      end
   end

   // read port, data one cycle after strobe
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         rdata_o <= 8'h00;
      else if (rd_i)
      begin
         unique case (addr_i)
            `PT8_OFF_COUNT:   rdata_o <= period_count;
            `PT8_OFF_LIMIT:   rdata_o <= period_limit;
            `PT8_OFF_CONTROL: rdata_o <= {timer_run_bit, prescale_select, postscale_select};
            `PT8_OFF_HLT:     rdata_o <= {3'h0, hw_mode};
            `PT8_OFF_STATUS:  rdata_o <= {5'h00, ers_prev, armed, event_flag};
            default:          rdata_o <= 8'h00;
         endcase
      end
      else
         rdata_o <= 8'h00;
   end
endmodule : pt8_period_timer

// ==== bench/pt8_ers_src.sv ====
// peripheral model driving the external reset signal
`timescale 1ns/100ps
module pt8_ers_src
(
   input  wire logic core_clk_i,
   input  wire logic rst_b_i,
   input  wire logic want_i,
   output logic      ers_o
);
   logic [3:0] gap;
   // edges at least seven clocks apart, levels held as long
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         ers_o <= 1'b0;
         gap   <= 4'h0;
      end
      else if (want_i != ers_o && gap >= 4'h6)
      begin
         ers_o <= want_i;
         gap   <= 4'h0;
      end
      else if (gap != 4'hF)
         gap <= gap + 4'h1;
   end
endmodule : pt8_ers_src

// ==== bench/pt8_period_timer_properties.sv ====
// port assertions of the period timer
`timescale 1ns/100ps
`include "pt8_map.svh"
module pt8_period_timer_checker
(
   input wire logic                   core_clk_i,
   input wire logic                   rst_b_i,
   input wire logic [`PT8_ADDR_W-1:0] addr_i,
   input wire logic [7:0]             wdata_i,
   input wire logic                   wr_i,
   input wire logic                   rd_i,
   input wire logic                   external_reset_signal_i,
   input wire logic                   debug_freeze_i,
   input wire logic [7:0]             rdata_o,
   input wire logic                   postscaled_period_pulse_o,
   input wire logic                   period_event_o
);
   logic [3:0] off_cnt;
   wire        wc = wr_i && addr_i == `PT8_OFF_CONTROL;
   // cycles since the run bit was written low
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
         off_cnt <= 4'hF;
      else if (wc)
         off_cnt <= wdata_i[7] ? 4'h0 : (off_cnt == 4'h0 ? 4'h1 : off_cnt);
      else if (off_cnt != 4'h0 && off_cnt != 4'hF)
         off_cnt <= off_cnt + 4'h1;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_pulse_single: assert property (
      postscaled_period_pulse_o |=> !postscaled_period_pulse_o) else $error("pulse too long");
   a_event_after_pulse: assert property (
      postscaled_period_pulse_o |=> period_event_o) else $error("no event flag");
   a_rdata_idle: assert property (
      !rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
   a_limit_readback: assert property (
      (wr_i && addr_i == `PT8_OFF_LIMIT) ##1 (rd_i && addr_i == `PT8_OFF_LIMIT)
      |=> rdata_o == $past(wdata_i, 2)) else $error("limit readback");
   a_unmapped_zero: assert property (
      rd_i && addr_i > `PT8_OFF_PRESCALE |=> rdata_o == 8'h00) else $error("unmapped read");
   a_reset_quiet: assert property (
      $rose(rst_b_i) |-> !postscaled_period_pulse_o && !period_event_o && rdata_o == 8'h00)
      else $error("outputs after reset");
   a_off_no_pulse: assert property (
      off_cnt > 4'h3 |-> !postscaled_period_pulse_o) else $error("pulse while off");
   a_ctrl_keeps_count: assert property (
      (off_cnt > 4'h3 && wr_i && addr_i == `PT8_OFF_COUNT) ##1 (wc && !wdata_i[7])
      ##1 (rd_i && addr_i == `PT8_OFF_COUNT) |=> rdata_o == $past(wdata_i, 3))
      else $error("control write moved count");
   c_pulse: cover property (postscaled_period_pulse_o);
   c_ctrl_write_off: cover property (off_cnt > 4'h3 && wc);
   c_frozen_ers: cover property (external_reset_signal_i && debug_freeze_i);
endmodule : pt8_period_timer_checker
bind pt8_period_timer pt8_period_timer_checker pt8_period_timer_checker_inst
(
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .external_reset_signal_i(external_reset_signal_i),
   .debug_freeze_i(debug_freeze_i), .rdata_o(rdata_o),
   .postscaled_period_pulse_o(postscaled_period_pulse_o), .period_event_o(period_event_o)
);

// ==== bench/pt8_period_timer_tb.sv ====
// self-checking bench for the period timer
`timescale 1ns/100ps
module pt8_period_timer_tb;
   logic       clk = 1'b0;
   logic       rst_b, wr, rd, rd_d, want, frz, ers, pulse, evt;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, l, s, p, r;
   logic [7:0] exp_q[$];
   int         n_fail = 0;
   int         n_tests = 0;
   int         n;
   always #12.5 clk = ~clk;
   pt8_period_timer pt8_period_timer_inst
   (
      .core_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .external_reset_signal_i(ers), .debug_freeze_i(frz), .rdata_o(rdata),
      .postscaled_period_pulse_o(pulse), .period_event_o(evt)
   );
   pt8_ers_src pt8_ers_src_inst (.core_clk_i(clk), .rst_b_i(rst_b), .want_i(want), .ers_o(ers));
   task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      exp_q.push_back(e);
   endtask : rd_reg
   task idle(input int k);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (k) @(posedge clk);
   endtask : idle
   task wait_p(output int k);
      k = 0;
      @(negedge clk);
      while (pulse !== 1'b1 && k < 2000)
      begin
         @(negedge clk);
         k++;
      end
   endtask : wait_p
   task tally_and_finish;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // read results checked against the oldest note
   always @(posedge clk)
   begin
      rd_d <= rd;
      if (rd_d === 1'b1)
         check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
   end
   initial
   begin
      #500000;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      {addr, wdata, wr, rd, rd_d, want, frz, rst_b} = '0;
      void'($urandom(31));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(3'h0, 8'h00);
      rd_reg(3'h1, 8'hFF);
      wr_reg(3'h6, 8'hA5);
      rd_reg(3'h6, 8'h00);
      r = 8'($urandom);
      wr_reg(3'h1, r);
      rd_reg(3'h1, r);
      idle(2);
      $display("registers done");
      repeat (4)
      begin
         l = 8'($urandom_range(6, 1));
         s = 8'($urandom_range(3, 0));
         p = 8'($urandom_range(3, 0));
         wr_reg(3'h1, l);
         wr_reg(3'h0, 8'h00);
         wr_reg(3'h2, 8'h80 | (s << 4) | p);
         idle(0);
         wait_p(n);
         wait_p(n);
         check("gap", 16'(n + 1), 16'((l + 1) * (1 << s) * (p + 1)));
      end
      $display("periods done");
      wr_reg(3'h2, 8'h00);
      idle(3);
      check("event", {15'h0000, evt}, 16'h0001);
      rd_reg(3'h4, 8'h01);
      wr_reg(3'h4, 8'h01);
      rd_reg(3'h4, 8'h00);
      idle(2);
      check("event clr", {15'h0000, evt}, 16'h0000);
      wr_reg(3'h0, 8'h05);
      wr_reg(3'h2, 8'h05);
      rd_reg(3'h0, 8'h05);
      idle(4);
      rd_reg(3'h0, 8'h05);
      wr_reg(3'h3, 8'h01);
      rd_reg(3'h3, 8'h01);
      wr_reg(3'h2, 8'h80);
      wr_reg(3'h0, 8'h33);
      idle(10);
      rd_reg(3'h0, 8'h33);
      idle(1);
      frz <= 1'b1;
      idle(2);
      want <= 1'b1;
      idle(20);
      rd_reg(3'h0, 8'h33);
      idle(1);
      frz <= 1'b0;
      wr_reg(3'h3, 8'h07);
      idle(10);
      rd_reg(3'h0, 8'h00);
      idle(1);
      want <= 1'b0;
      idle(10);
      $display("external done");
      wr_reg(3'h3, 8'h08);
      wr_reg(3'h1, 8'h03);
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h2, 8'h80);
      idle(30);
      rd_reg(3'h2, 8'h00);
      wr_reg(3'h3, 8'h11);
      wr_reg(3'h2, 8'h80);
      idle(8);
      want <= 1'b1;
      idle(30);
      rd_reg(3'h2, 8'h80);
      idle(3);
      $display("modes done");
      tally_and_finish();
   end
endmodule : pt8_period_timer_tb
